//--- hdl/sgfc_top.sv
// slider, gesture and filter configuration bank with the logic that
// the settings steer. assumes a synchronous register port that the
// serial host interface drives, and sensing inputs on clk_sys.
//
// Operation
// - enter debounce counts conversions; zero disables it
// - eight-bit threshold decides movement
// - lower slider calibration in setup high byte
// - static bit picks dynamic or static filtering
// - static beta is three bits, bits 5-3
// - bits 2-0 give slider channel count
// - bottom speed high, upper calibration low
// - mask bits 0-2 include channels 0-2
// - touch gate pointer enables slider during touch
// - three links order elements; zero disables
// - gesture enable bits gate tap swipe flick hold
// - counts beta chosen by power mode
// - average beta chosen by power mode
// - fast average beta chosen by power mode
// - exit debounce counts conversions; zero disables it
// - control bit 7 selects streaming or events
`timescale 1ns/1ps
`include "sgfc_regs.svh"
module sgfc_top
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic movement_variant,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    input wire logic conv_strobe,
    input wire logic [7:0] movement_delta,
    input wire logic [2:0] channel_touch,
    input wire logic auto_low_power,
    input wire logic [3:0] gesture_raw,
    output logic movement_detected,
    output logic slider_active,
    output logic [2:0] slider_channels_used,
    output logic [2:0] slider_total_channels,
    output logic slider_static_filter,
    output logic [2:0] slider_static_beta,
    output logic [7:0] slider_lower_cal,
    output logic [7:0] slider_upper_cal,
    output logic [7:0] slider_bottom_speed,
    output logic [5:0] element_channel,
    output logic [2:0] element_valid,
    output logic [3:0] gesture_out,
    output logic low_power_selected,
    output logic [7:0] counts_beta_active,
    output logic [7:0] average_beta_active,
    output logic [7:0] fast_average_beta_active,
    output logic event_mode
);

    // configuration registers
    logic [15:0] movement_q;
    logic [15:0] setup_q;
    logic [15:0] cal_q;
    logic [15:0] mask_q;
    logic [15:0] gate_q;
    logic [15:0] link_q [3];
    logic [15:0] gesture_q;
    logic [15:0] counts_beta_q;
    logic [15:0] avg_beta_q;
    logic [15:0] fast_avg_beta_q;
    logic [15:0] sys_control_q;

    // decoded state
    logic [15:0] rdata_d;
    logic [15:0] gate_expect;
    logic raw_move;
    logic low_power_d;
    logic [2:0] touch_masked;
    logic [5:0] elem_chan_d;
    logic [2:0] elem_valid_d;
    sgfc_pkg::sgfc_power_mode_t power_mode;

    // link code to channel number for the active variant
    function automatic logic [2:0] sgfc_link_decode
    (
        input logic [15:0] code,
        input logic movement
    );
        logic [2:0] result;
        result = 3'b000;
        if (code == `SGFC_LINK_CH0)
        begin
            result = 3'b100;
        end
        else if (!movement && code == `SGFC_LINK_CH1_RELEASE)
        begin
            result = 3'b101;
        end
        else if (!movement && code == `SGFC_LINK_CH2_RELEASE)
        begin
            result = 3'b110;
        end
        else if (movement && code == `SGFC_LINK_CH1_MOVEMENT)
        begin
            result = 3'b101;
        end
        else if (movement && code == `SGFC_LINK_CH2_MOVEMENT)
        begin
            result = 3'b110;
        end
        return result;
    endfunction

    // register writes, reserved bits dropped
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            movement_q <= `SGFC_RESET_VALUE;
            setup_q <= `SGFC_RESET_VALUE;
            cal_q <= `SGFC_RESET_VALUE;
            mask_q <= `SGFC_RESET_VALUE;
            gate_q <= `SGFC_RESET_VALUE;
            gesture_q <= `SGFC_RESET_VALUE;
            counts_beta_q <= `SGFC_RESET_VALUE;
            avg_beta_q <= `SGFC_RESET_VALUE;
            fast_avg_beta_q <= `SGFC_RESET_VALUE;
            sys_control_q <= `SGFC_RESET_VALUE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SGFC_OFF_MOVEMENT: movement_q <= reg_wdata;
                `SGFC_OFF_SLIDER_SETUP: setup_q <= reg_wdata;
                `SGFC_OFF_SLIDER_CAL: cal_q <= reg_wdata;
                `SGFC_OFF_CHANNEL_MASK: mask_q <= reg_wdata & `SGFC_MASK_CHANNEL;
                `SGFC_OFF_TOUCH_GATE: gate_q <= reg_wdata;
                `SGFC_OFF_GESTURE: gesture_q <= reg_wdata & `SGFC_MASK_GESTURE;
                `SGFC_OFF_COUNTS_BETA: counts_beta_q <= reg_wdata;
                `SGFC_OFF_AVG_BETA: avg_beta_q <= reg_wdata;
                `SGFC_OFF_FAST_AVG_BETA: fast_avg_beta_q <= reg_wdata;
                `SGFC_OFF_SYS_CONTROL: sys_control_q <= reg_wdata & `SGFC_MASK_SYS_CONTROL;
                default: movement_q <= movement_q;
            endcase
        end
    end

    // element link registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            link_q[0] <= `SGFC_RESET_VALUE;
            link_q[1] <= `SGFC_RESET_VALUE;
            link_q[2] <= `SGFC_RESET_VALUE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SGFC_OFF_LINK_0: link_q[0] <= reg_wdata;
                `SGFC_OFF_LINK_1: link_q[1] <= reg_wdata;
                `SGFC_OFF_LINK_2: link_q[2] <= reg_wdata;
                default: link_q[0] <= link_q[0];
            endcase
        end
    end

    // read multiplexer, unmapped index reads zero
    always_comb
    begin
        case (reg_addr)
            `SGFC_OFF_MOVEMENT: rdata_d = movement_q;
            `SGFC_OFF_SLIDER_SETUP: rdata_d = setup_q;
            `SGFC_OFF_SLIDER_CAL: rdata_d = cal_q;
            `SGFC_OFF_CHANNEL_MASK: rdata_d = mask_q;
            `SGFC_OFF_TOUCH_GATE: rdata_d = gate_q;
            `SGFC_OFF_LINK_0: rdata_d = link_q[0];
            `SGFC_OFF_LINK_1: rdata_d = link_q[1];
            `SGFC_OFF_LINK_2: rdata_d = link_q[2];
            `SGFC_OFF_GESTURE: rdata_d = gesture_q;
            `SGFC_OFF_COUNTS_BETA: rdata_d = counts_beta_q;
            `SGFC_OFF_AVG_BETA: rdata_d = avg_beta_q;
            `SGFC_OFF_FAST_AVG_BETA: rdata_d = fast_avg_beta_q;
            `SGFC_OFF_SYS_CONTROL: rdata_d = sys_control_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    // register port answer one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
        end
        else
        begin
            reg_ack <= reg_wr | reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= rdata_d;
            end
        end
    end

    // movement compare against the threshold
    assign raw_move = movement_delta > movement_q[7:0];

    // enter and exit debounce of movement
    sgfc_debounce u_debounce
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .conv_strobe(conv_strobe),
        .raw_move(raw_move),
        .enter_count(movement_q[11:8]),
        .exit_count(movement_q[15:12]),
        .moving(movement_detected)
    );

    // touch gate: pointer must hold the value for this variant
    assign gate_expect = movement_variant ? `SGFC_GATE_MOVEMENT : `SGFC_GATE_RELEASE;
    assign touch_masked = channel_touch & mask_q[2:0];

    // element link decode
    always_comb
    begin
        logic [2:0] dec;
        dec = 3'b000;
        elem_chan_d = 6'h00;
        elem_valid_d = 3'b000;
        for (int k = 0; k < 3; k++)
        begin
            dec = sgfc_link_decode(link_q[k], movement_variant);
            elem_valid_d[k] = dec[2];
            elem_chan_d[2 * k +: 2] = dec[1:0];
        end
    end

    // slider state outputs
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            slider_active <= 1'b0;
            slider_channels_used <= 3'b000;
            element_channel <= 6'h00;
            element_valid <= 3'b000;
        end
        else
        begin
            slider_active <= (gate_q == gate_expect) && (touch_masked != 3'b000);
            slider_channels_used <= mask_q[2:0];
            element_channel <= elem_chan_d;
            element_valid <= elem_valid_d;
        end
    end

    // slider setup and calibration fields
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            slider_total_channels <= 3'b000;
            slider_static_filter <= 1'b0;
            slider_static_beta <= 3'b000;
            slider_lower_cal <= 8'h00;
            slider_upper_cal <= 8'h00;
            slider_bottom_speed <= 8'h00;
        end
        else
        begin
            slider_total_channels <= setup_q[2:0];
            slider_static_filter <= setup_q[`SGFC_POS_STATIC_FILTER];
            slider_static_beta <= setup_q[5:3];
            slider_lower_cal <= setup_q[15:8];
            slider_upper_cal <= cal_q[7:0];
            slider_bottom_speed <= cal_q[15:8];
        end
    end

    // gestures pass only when enabled
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            gesture_out <= 4'h0;
        end
        else
        begin
            gesture_out <= gesture_raw & gesture_q[3:0];
        end
    end

    // low-power betas in low, ultra low, or automatic while low
    assign power_mode = sgfc_pkg::sgfc_power_mode_t'(sys_control_q[6:4]);
    always_comb
    begin
        case (power_mode)
            sgfc_pkg::SGFC_PM_LOW: low_power_d = 1'b1;
            sgfc_pkg::SGFC_PM_ULTRA_LOW: low_power_d = 1'b1;
            sgfc_pkg::SGFC_PM_AUTO: low_power_d = auto_low_power;
            sgfc_pkg::SGFC_PM_AUTO_NO_ULP: low_power_d = auto_low_power;
            default: low_power_d = 1'b0;
        endcase
    end

    // active filter betas for the current power mode
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            low_power_selected <= 1'b0;
            counts_beta_active <= 8'h00;
            average_beta_active <= 8'h00;
            fast_average_beta_active <= 8'h00;
        end
        else
        begin
            low_power_selected <= low_power_d;
            counts_beta_active <= low_power_d ? counts_beta_q[15:8] : counts_beta_q[7:0];
            average_beta_active <= low_power_d ? avg_beta_q[15:8] : avg_beta_q[7:0];
            fast_average_beta_active <= low_power_d ? fast_avg_beta_q[15:8] : fast_avg_beta_q[7:0];
        end
    end

    // reporting mode for the serial interface
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            event_mode <= 1'b0;
        end
        else
        begin
            event_mode <= sys_control_q[`SGFC_POS_INTERFACE_TYPE];
        end
    end

endmodule

//--- hdl/sgfc_regs.svh
// register offsets, field positions, reset values and link codes
// of the slider, gesture and filter configuration bank.
// assumes 8-bit register index and 16-bit register data.
`ifndef SGFC_REGS_SVH
`define SGFC_REGS_SVH

// register index on the register port
`define SGFC_OFF_MOVEMENT 8'h64
`define SGFC_OFF_SLIDER_SETUP 8'h90
`define SGFC_OFF_SLIDER_CAL 8'h91
`define SGFC_OFF_CHANNEL_MASK 8'h94
`define SGFC_OFF_TOUCH_GATE 8'h95
`define SGFC_OFF_LINK_0 8'h96
`define SGFC_OFF_LINK_1 8'h97
`define SGFC_OFF_LINK_2 8'h98
`define SGFC_OFF_GESTURE 8'hA0
`define SGFC_OFF_COUNTS_BETA 8'hB0
`define SGFC_OFF_AVG_BETA 8'hB1
`define SGFC_OFF_FAST_AVG_BETA 8'hB2
`define SGFC_OFF_SYS_CONTROL 8'hC0

// writable bits of registers with reserved fields
`define SGFC_MASK_CHANNEL 16'h0007
`define SGFC_MASK_GESTURE 16'h000F
`define SGFC_MASK_SYS_CONTROL 16'h00F0

// field positions
`define SGFC_POS_STATIC_FILTER 6
`define SGFC_POS_INTERFACE_TYPE 7

// reset value of every register
`define SGFC_RESET_VALUE 16'h0000

// touch gate pointer values per interface variant
`define SGFC_GATE_RELEASE 16'h0552
`define SGFC_GATE_MOVEMENT 16'h0558

// element link codes
`define SGFC_LINK_OFF 16'h0000
`define SGFC_LINK_CH0 16'h0430
`define SGFC_LINK_CH1_RELEASE 16'h0472
`define SGFC_LINK_CH2_RELEASE 16'h04B4
`define SGFC_LINK_CH1_MOVEMENT 16'h0474
`define SGFC_LINK_CH2_MOVEMENT 16'h04B8

`endif

//--- hdl/sgfc_pkg.sv
// types shared by the configuration bank and its debounce unit.
// assumes nothing of its surroundings.
package sgfc_pkg;

    // power mode field of the system control register
    typedef enum logic [2:0]
    {
        SGFC_PM_NORMAL = 3'b000,
        SGFC_PM_LOW = 3'b001,
        SGFC_PM_ULTRA_LOW = 3'b010,
        SGFC_PM_HALT = 3'b011,
        SGFC_PM_AUTO = 3'b100,
        SGFC_PM_AUTO_NO_ULP = 3'b101
    } sgfc_power_mode_t;

    // movement debounce state
    typedef enum logic [0:0]
    {
        SGFC_MV_IDLE = 1'b0,
        SGFC_MV_MOVING = 1'b1
    } sgfc_move_state_t;

endpackage

//--- hdl/sgfc_debounce.sv
// movement debounce: counts consecutive conversions before entering
// or leaving movement. assumes one conv_strobe pulse per conversion.
`timescale 1ns/1ps
module sgfc_debounce
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic conv_strobe,
    input wire logic raw_move,
    input wire logic [3:0] enter_count,
    input wire logic [3:0] exit_count,
    output logic moving
);

    sgfc_pkg::sgfc_move_state_t state_q;
    logic [3:0] run_q;
    logic [3:0] target;
    logic toward;

    // a conversion pushes toward the other state
    assign toward = (state_q == sgfc_pkg::SGFC_MV_IDLE) ? raw_move : !raw_move;
    assign target = (state_q == sgfc_pkg::SGFC_MV_IDLE) ? enter_count : exit_count;
    assign moving = (state_q == sgfc_pkg::SGFC_MV_MOVING);

    // state change after target consecutive conversions, zero means at once
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_q <= sgfc_pkg::SGFC_MV_IDLE;
            run_q <= 4'h0;
        end
        else if (conv_strobe)
        begin
            if (!toward)
            begin
                run_q <= 4'h0;
            end
            else if (target == 4'h0 || run_q + 4'h1 >= target)
            begin
                run_q <= 4'h0;
                case (state_q)
                    sgfc_pkg::SGFC_MV_IDLE: state_q <= sgfc_pkg::SGFC_MV_MOVING;
                    sgfc_pkg::SGFC_MV_MOVING: state_q <= sgfc_pkg::SGFC_MV_IDLE;
                    default: state_q <= sgfc_pkg::SGFC_MV_IDLE;
                endcase
            end
            else
            begin
                run_q <= run_q + 4'h1;
            end
        end
    end

endmodule

//--- bench/sgfc_top_checker.sv
// port checks for the configuration bank.
// assumes clk_sys and a synchronous active-high srst.
`timescale 1ns/1ps
module sgfc_top_checker
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic conv_strobe,
    input wire logic [2:0] channel_touch,
    input wire logic [3:0] gesture_raw,
    input wire logic movement_detected,
    input wire logic slider_active,
    input wire logic [2:0] slider_channels_used,
    input wire logic [7:0] slider_lower_cal,
    input wire logic [7:0] slider_upper_cal,
    input wire logic [7:0] slider_bottom_speed,
    input wire logic [3:0] gesture_out
);
    // one clock domain for all checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    a_ack_follows_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("no ack after request");
    a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
        else $error("ack without request");
    a_unmapped_reads_zero: assert property (reg_rd && reg_addr == 8'h99 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_lower_cal_write: assert property (reg_wr && reg_addr == 8'h90
        |-> ##2 slider_lower_cal == $past(reg_wdata[15:8], 2))
        else $error("lower cal not taken");
    a_cal_speed_write: assert property (reg_wr && reg_addr == 8'h91
        |-> ##2 {slider_bottom_speed, slider_upper_cal} == $past(reg_wdata, 2))
        else $error("upper cal or speed not taken");
    a_mask_write: assert property (reg_wr && reg_addr == 8'h94
        |-> ##2 slider_channels_used == $past(reg_wdata[2:0], 2))
        else $error("channel mask not taken");
    a_gesture_gated: assert property ((gesture_out & ~$past(gesture_raw)) == 4'h0)
        else $error("gesture without raw cause");
    a_move_on_strobe: assert property ($changed(movement_detected) |-> $past(conv_strobe))
        else $error("movement changed without conversion");
    a_slider_needs_touch: assert property (slider_active |-> $past(channel_touch) != 3'h0)
        else $error("slider active without touch");
endmodule

bind sgfc_top sgfc_top_checker sgfc_top_checker_inst (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_ack, .conv_strobe, .channel_touch, .gesture_raw, .movement_detected, .slider_active,
    .slider_channels_used, .slider_lower_cal, .slider_upper_cal, .slider_bottom_speed, .gesture_out);

//--- bench/sgfc_host_model.sv
// host model: drives the register port one request at a time.
// assumes the bank acks one cycle after each request.
`timescale 1ns/1ps
module sgfc_host_model
(
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack
);
    // idle port at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one write or read, data released to its inverse after the pulse
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        int n;
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
        for (n = 0; n < 4 && reg_ack !== 1'b1; n++)
            @(posedge clk_sys);
        q = reg_rdata;
    endtask
endmodule

//--- bench/sgfc_top_test.sv
// self-checking bench of the configuration bank.
// assumes sgfc_top, the host model and the checker bound to it.
`timescale 1ns/1ps
module sgfc_top_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic movement_variant = 1'b0;
    logic conv_strobe = 1'b0;
    logic [7:0] movement_delta = 8'h00;
    logic [2:0] channel_touch = 3'h0;
    logic auto_low_power = 1'b0;
    logic [3:0] gesture_raw = 4'h0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q, d;
    logic reg_wr, reg_rd, reg_ack, movement_detected, slider_active, slider_static_filter;
    logic low_power_selected, event_mode, lp;
    logic [2:0] slider_channels_used, slider_total_channels, slider_static_beta, element_valid;
    logic [7:0] slider_lower_cal, slider_upper_cal, slider_bottom_speed;
    logic [7:0] counts_beta_active, average_beta_active, fast_average_beta_active;
    logic [5:0] element_channel;
    logic [3:0] gesture_out;
    logic [15:0] tbl [5];
    logic [15:0] wv [14];
    logic [7:0] offs [14] = '{8'h64, 8'h90, 8'h91, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'hA0, 8'hB0, 8'hB1,
        8'hB2, 8'hC0, 8'h99};
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    sgfc_top sgfc_top_inst (.clk_sys, .srst, .movement_variant, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_ack, .conv_strobe, .movement_delta, .channel_touch, .auto_low_power, .gesture_raw,
        .movement_detected, .slider_active, .slider_channels_used, .slider_total_channels, .slider_static_filter,
        .slider_static_beta, .slider_lower_cal, .slider_upper_cal, .slider_bottom_speed, .element_channel,
        .element_valid, .gesture_out, .low_power_selected, .counts_beta_active, .average_beta_active,
        .fast_average_beta_active, .event_mode);
    sgfc_host_model sgfc_host_model_inst (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_ack);

    // clock and hang limit
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // writable bits per register
    function automatic logic [15:0] keep(input logic [7:0] a, input logic [15:0] v);
        case (a)
            8'h94: keep = v & 16'h0007;
            8'hA0: keep = v & 16'h000F;
            8'hC0: keep = v & 16'h00F0;
            8'h99: keep = 16'h0000;
            default: keep = v;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        sgfc_host_model_inst.access(1'b1, a, v, q);
    endtask

    task automatic strobe(input logic [7:0] dl);
        @(posedge clk_sys);
        #1;
        conv_strobe = 1'b1;
        movement_delta = dl;
        @(posedge clk_sys);
        #1;
        conv_strobe = 1'b0;
        movement_delta = ~dl;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'hA913));
        repeat (8) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        // reset values, then random write and readback
        foreach (offs[i])
        begin
            sgfc_host_model_inst.access(1'b0, offs[i], 16'h0000, q);
            check(q, 16'h0000);
            d = $urandom;
            if (i == 12)
                d[6:4] = 3'($urandom_range(5));
            wv[i] = d;
            wr(offs[i], d);
            sgfc_host_model_inst.access(1'b0, offs[i], 16'h0000, q);
            check(q, keep(offs[i], d));
        end
        repeat (3) @(posedge clk_sys);
        check(slider_lower_cal, wv[1][15:8]);
        check(slider_static_filter, wv[1][6]);
        check(slider_static_beta, wv[1][5:3]);
        check(slider_total_channels, wv[1][2:0]);
        check({slider_bottom_speed, slider_upper_cal}, wv[2]);
        check(slider_channels_used, wv[3][2:0]);
        check(event_mode, wv[12][7]);
        $display("test registers done");
        // every power mode with and without automatic low power
        for (int m = 0; m < 12; m++)
        begin
            wr(8'hC0, {8'h00, m[0], 3'(m / 2), 4'h0});
            auto_low_power = m[0];
            repeat (3) @(posedge clk_sys);
            lp = (m / 2 == 1) || (m / 2 == 2) || (m / 2 >= 4 && m[0]);
            check(event_mode, m[0]);
            check(low_power_selected, lp);
            check(counts_beta_active, lp ? wv[9][15:8] : wv[9][7:0]);
            check(average_beta_active, lp ? wv[10][15:8] : wv[10][7:0]);
            check(fast_average_beta_active, lp ? wv[11][15:8] : wv[11][7:0]);
        end
        $display("test betas done");
        // link codes and touch gate per variant
        for (int v = 0; v < 2; v++)
        begin
            #1;
            movement_variant = v[0];
            tbl = '{16'h0000, 16'h0430, v ? 16'h0474 : 16'h0472, v ? 16'h04B8 : 16'h04B4, v ? 16'h04B4 : 16'h04B8};
            for (int j = 0; j < 5; j++)
            begin
                for (int k = 0; k < 3; k++)
                    wr(8'h96 + 8'(k), tbl[(j + k) % 5]);
                repeat (3) @(posedge clk_sys);
                for (int k = 0; k < 3; k++)
                begin
                    d = 16'((j + k) % 5);
                    check(element_valid[k], d inside {1, 2, 3});
                    check(element_channel[2 * k +: 2], (d inside {1, 2, 3}) ? d - 16'h0001 : 16'h0000);
                end
            end
            for (int g = 0; g < 4; g++)
            begin
                d = g[0] ? (v ? 16'h0558 : 16'h0552) : (v ? 16'h0552 : 16'h0558);
                wr(8'h95, d);
                wv[3] = 16'($urandom);
                wr(8'h94, wv[3]);
                channel_touch = 3'($urandom);
                repeat (3) @(posedge clk_sys);
                check(slider_active, g[0] && (channel_touch & wv[3][2:0]) != 3'h0);
            end
        end
        #1;
        channel_touch = 3'h0;
        $display("test links and gate done");
        // gesture gating
        repeat (6)
        begin
            d = $urandom;
            wr(8'hA0, d);
            gesture_raw = 4'($urandom);
            repeat (3) @(posedge clk_sys);
            check(gesture_out, gesture_raw & d[3:0]);
        end
        $display("test gestures done");
        // debounce: enter 3, exit 2, threshold 0x40 not exceeded at equality
        wr(8'h64, 16'h2340);
        strobe(8'h41);
        strobe(8'h41);
        strobe(8'h40);
        strobe(8'hFF);
        strobe(8'hFF);
        repeat (2) @(posedge clk_sys);
        check(movement_detected, 1'b0);
        strobe(8'h41);
        repeat (2) @(posedge clk_sys);
        check(movement_detected, 1'b1);
        strobe(8'h40);
        strobe(8'h90);
        strobe(8'h40);
        repeat (2) @(posedge clk_sys);
        check(movement_detected, 1'b1);
        strobe(8'h00);
        repeat (2) @(posedge clk_sys);
        check(movement_detected, 1'b0);
        wr(8'h64, 16'h0010);
        strobe(8'h11);
        repeat (2) @(posedge clk_sys);
        check(movement_detected, 1'b1);
        strobe(8'h10);
        repeat (2) @(posedge clk_sys);
        check(movement_detected, 1'b0);
        $display("test movement done");
        test_done();
    end
endmodule
